/* File: core/ums_pkg.sv */
// constants, types and behaviour notes for the uart modem status channel
package ums_pkg;
    // register addresses on the three-bit address pins
    localparam logic [2:0] ADR_DATA     = 3'h0;
    localparam logic [2:0] ADR_INT_EN   = 3'h1;
    localparam logic [2:0] ADR_INT_ST   = 3'h2;
    localparam logic [2:0] ADR_LINE_FMT = 3'h3;
    localparam logic [2:0] ADR_MDM_CTL  = 3'h4;
    localparam logic [2:0] ADR_LINE_ST  = 3'h5;
    localparam logic [2:0] ADR_MDM_ST   = 3'h6;
    localparam logic [2:0] ADR_SCR      = 3'h7;
    // values after reset
    localparam logic [7:0] INT_EN_RST   = 8'h00;
    localparam logic [7:0] LINE_FMT_RST = 8'h00;
    localparam logic [7:0] MDM_CTL_RST  = 8'h00;
    localparam logic [7:0] SCR_RST      = 8'h00;
    localparam logic [7:0] LINE_ST_RST  = 8'h60;
    localparam logic [3:0] INT_NONE     = 4'h1;
    localparam logic [3:0] DLT_RST      = 4'h0;
    // interrupt identification codes, highest priority first
    localparam logic [3:0] INT_LINE     = 4'h6;
    localparam logic [3:0] INT_RX       = 4'h4;
    localparam logic [3:0] INT_TX       = 4'h2;
    localparam logic [3:0] INT_MDM      = 4'h0;
    // field positions
    localparam int CTL_DTR  = 0;
    localparam int CTL_RTS  = 1;
    localparam int CTL_OUT1 = 2;
    localparam int CTL_OUT2 = 3;
    localparam int CTL_LOOP = 4;
    localparam int FMT_BRK  = 6;
    localparam int EN_RX    = 0;
    localparam int EN_TX    = 1;
    localparam int EN_LINE  = 2;
    localparam int EN_MDM   = 3;
    // timing: one receive clock is one core clock
    localparam int CLK_NS       = 8;
    localparam int RCLK_NS      = 8;
    localparam int TX_MIN_RCLK  = 8;
    localparam int TX_START_DLY = (TX_MIN_RCLK * RCLK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] TX_CNT_END = 5'(TX_START_DLY - 1);
    // modem inputs, order matches status bits 7..4
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } ums_modem_t;
endpackage

/* File: core/ums_channel.sv */
// one uart channel: modem status, scratch, reset defaults and event timing
`timescale 1ns/1ns
module ums_channel (
    input  wire logic               i_clk,               // core and receive clock
    input  wire logic               i_rst_b,             // async reset, active low
    input  wire logic               i_cs_n,              // chip select, active low
    input  wire logic [2:0]         i_addr,              // register address
    input  wire logic               i_read_strobe_n,     // read strobe, active low
    input  wire logic               i_write_strobe_n,    // write strobe, active low
    input  wire logic [7:0]         i_data,              // write data
    output logic [7:0]              o_data,              // read data
    output logic                    o_data_oe,           // read data drive enable
    input  wire ums_pkg::ums_modem_t i_modem_n,          // cd, ri, dsr, cts, active low
    input  wire logic               i_rx_stop,           // stop bit sampled pulse
    input  wire logic [7:0]         i_rx_byte,           // received character
    input  wire logic [3:0]         i_rx_err,            // break, framing, parity, overrun
    input  wire logic               i_tx_bit,            // serialiser line level
    input  wire logic               i_tx_done,           // shifter emptied pulse
    output logic                    o_tx,                // serial out
    output logic                    o_tx_load,           // start of character pulse
    output logic [7:0]              o_tx_byte,           // character for serialiser
    output logic                    o_rts_n,             // request to send
    output logic                    o_dtr_n,             // terminal ready
    output logic                    o_irq,               // interrupt level
    output logic                    o_irq_oe,            // interrupt pin enable
    output logic                    o_receive_ready_n,   // receive ready
    output logic                    o_transmit_ready_n   // transmit ready
);
    import ums_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic       rd_act;
    logic       wr_act;
    logic       rd_act_q;
    logic       wr_act_q;
    logic       rd_end;
    logic       wr_go;
    logic [2:0] rd_adr_q;
    assign rd_act = ~i_cs_n & ~i_read_strobe_n;
    assign wr_act = ~i_cs_n & ~i_write_strobe_n;
    assign wr_go  = wr_act & ~wr_act_q;
    assign rd_end = rd_act_q & ~rd_act;

    function automatic logic hit(input logic go, input logic [2:0] a, input logic [2:0] r);
        hit = go && (a == r);
    endfunction

    // strobe history for edge detection
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            rd_adr_q <= 3'h0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (rd_act) begin
                rd_adr_q <= i_addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_format_reg;
    logic [7:0] modem_output_control_reg;
    logic [7:0] scratch_byte;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            interrupt_enable_reg     <= INT_EN_RST;
            line_format_reg          <= LINE_FMT_RST;
            modem_output_control_reg <= MDM_CTL_RST;
            scratch_byte             <= SCR_RST;
        end else begin
            if (hit(wr_go, i_addr, ADR_INT_EN)) interrupt_enable_reg <= {4'h0, i_data[3:0]};
            if (hit(wr_go, i_addr, ADR_LINE_FMT)) line_format_reg <= {1'b0, i_data[6:0]};
            if (hit(wr_go, i_addr, ADR_MDM_CTL)) modem_output_control_reg <= {3'h0, i_data[4:0]};
            if (hit(wr_go, i_addr, ADR_SCR)) scratch_byte <= i_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem input synchroniser and status
    ums_modem_t m_s1;
    ums_modem_t m_s2;
    logic [3:0] st_now;
    logic [3:0] st_q;
    logic       st_valid;
    logic [3:0] dlt_reg;
    logic [3:0] dlt_set;
    logic       loop;
    logic       mls_clr;
    assign loop = modem_output_control_reg[CTL_LOOP];
    // status nibble: inverted inputs or loop-back controls
    assign st_now = loop ? {modem_output_control_reg[CTL_OUT2], modem_output_control_reg[CTL_OUT1],
                            modem_output_control_reg[CTL_DTR], modem_output_control_reg[CTL_RTS]}
                         : ~m_s2;
    // cts, dsr, cd on any change; ring only on trailing edge of ring
    assign dlt_set = st_valid ? {st_q[3] ^ st_now[3], st_q[2] & ~st_now[2],
                                 st_q[1] ^ st_now[1], st_q[0] ^ st_now[0]} : 4'h0;
    assign mls_clr = rd_end && (rd_adr_q == ADR_MDM_ST);

    // two flops before any edge logic
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            m_s1 <= '1;
            m_s2 <= '1;
        end else begin
            m_s1 <= i_modem_n;
            m_s2 <= m_s1;
        end
    end

    // change bits: a set in the clearing cycle wins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q     <= 4'h0;
            st_valid <= 1'b0;
            dlt_reg  <= DLT_RST;
        end else begin
            st_q     <= st_now;
            st_valid <= 1'b1;
            dlt_reg  <= (mls_clr ? 4'h0 : dlt_reg) | dlt_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive side
    logic       rx_rdy;
    logic [3:0] ls_err;
    logic [7:0] rhr;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_rdy <= 1'b0;
            ls_err <= 4'h0;
            rhr    <= 8'h00;
        end else begin
            if (i_rx_stop) begin
                rx_rdy <= 1'b1;
                rhr    <= rx_rdy ? rhr : i_rx_byte;
            end else if (rd_end && rd_adr_q == ADR_DATA) begin
                rx_rdy <= 1'b0;
            end
            // a clearing read drops old errors but never those of a new character
            ls_err <= ((rd_end && rd_adr_q == ADR_LINE_ST) ? 4'h0 : ls_err)
                      | (i_rx_stop ? (rx_rdy ? 4'h1 : i_rx_err) : 4'h0);
        end
    end
    assign o_receive_ready_n = ~rx_rdy;

    ////////////////////////////////////////////////////////////////////////
    // transmit side
    logic [7:0] thr;
    logic       thr_full;
    logic       tx_busy;
    logic       tx_int;
    logic       tx_pend;
    logic [4:0] tx_cnt;
    logic       tx_go;
    logic       thr_wr;
    logic       int_rd_tx;
    logic [3:0] int_code;
    assign thr_wr = hit(wr_go, i_addr, ADR_DATA);
    assign tx_go  = tx_pend && (tx_cnt == TX_CNT_END) && !tx_busy;
    assign int_rd_tx = rd_end && rd_adr_q == ADR_INT_ST && int_code == INT_TX;

    // holding register and start delay after the clearing write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            thr      <= 8'h00;
            thr_full <= 1'b0;
            tx_pend  <= 1'b0;
            tx_cnt   <= 5'h00;
            tx_int   <= 1'b1;
        end else begin
            if (thr_wr) begin
                thr      <= i_data;
                thr_full <= 1'b1;
                tx_pend  <= 1'b1;
                tx_cnt   <= 5'h00;
                tx_int   <= 1'b0;
            end else if (tx_go) begin
                thr_full <= 1'b0;
                tx_pend  <= 1'b0;
                tx_int   <= 1'b1;
            end else begin
                if (tx_pend && tx_cnt != TX_CNT_END) tx_cnt <= tx_cnt + 5'h01;
                if (int_rd_tx) tx_int <= 1'b0;
            end
        end
    end

    // shifter hand-off and line pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_busy            <= 1'b0;
            o_tx_load          <= 1'b0;
            o_tx_byte          <= 8'h00;
            o_tx               <= 1'b1;
            o_transmit_ready_n <= 1'b0;
        end else begin
            o_tx_load <= tx_go;
            o_tx      <= line_format_reg[FMT_BRK] ? 1'b0 : i_tx_bit;
            if (tx_go) begin
                o_tx_byte <= thr;
                tx_busy   <= 1'b1;
            end else if (i_tx_done) begin
                tx_busy   <= 1'b0;
            end
            if (o_tx_load) begin
                o_transmit_ready_n <= 1'b1;
            end else if (!tx_busy && !thr_full) begin
                o_transmit_ready_n <= 1'b0;
            end
        end
    end

    // modem outputs follow the control bits
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dtr_n  <= 1'b1;
            o_rts_n  <= 1'b1;
            o_irq_oe <= 1'b0;
        end else begin
            o_dtr_n  <= ~modem_output_control_reg[CTL_DTR];
            o_rts_n  <= ~modem_output_control_reg[CTL_RTS];
            o_irq_oe <= modem_output_control_reg[CTL_OUT2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt priority
    logic [7:0] line_state_reg;
    always_comb begin
        if (interrupt_enable_reg[EN_LINE] && |ls_err) int_code = INT_LINE;
        else if (interrupt_enable_reg[EN_RX] && rx_rdy) int_code = INT_RX;
        else if (interrupt_enable_reg[EN_TX] && tx_int) int_code = INT_TX;
        else if (interrupt_enable_reg[EN_MDM] && |dlt_reg) int_code = INT_MDM;
        else int_code = INT_NONE;
    end
    assign o_irq = ~int_code[0];
    assign line_state_reg = {1'b0, !tx_busy && !thr_full, !thr_full, ls_err, rx_rdy};

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_data    <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= rd_act;
            case (i_addr)
                ADR_DATA: o_data <= rhr;
                ADR_INT_EN:   o_data <= interrupt_enable_reg;
                ADR_INT_ST:   o_data <= {4'h0, int_code};
                ADR_LINE_FMT: o_data <= line_format_reg;
                ADR_MDM_CTL:  o_data <= modem_output_control_reg;
                ADR_LINE_ST:  o_data <= line_state_reg;
                ADR_MDM_ST:   o_data <= {st_now, dlt_reg};
                ADR_SCR:  o_data <= scratch_byte;
                default:  o_data <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_cts_chg;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st_valid && st_q[0] != st_now[0]) |=> dlt_reg[0];
    endproperty
    a_cts_chg: assert property (p_cts_chg) else $error("cts change lost");

    property p_clr;
        @(posedge i_clk) disable iff (!i_rst_b)
        (mls_clr && dlt_set == 4'h0) |=> dlt_reg == 4'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("change bits not cleared");

    property p_ri_rise;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st_valid && !st_q[2] && st_now[2] && !dlt_reg[2]) |=> !dlt_reg[2];
    endproperty
    a_ri_rise: assert property (p_ri_rise) else $error("ring lead edge flagged");

    property p_keep;
        @(posedge i_clk) disable iff (!i_rst_b)
        (mls_clr && dlt_set[1]) |=> dlt_reg[1];
    endproperty
    a_keep: assert property (p_keep) else $error("change lost at read");

    property p_rx;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_stop && interrupt_enable_reg[EN_RX]) |=> (!o_receive_ready_n && o_irq);
    endproperty
    a_rx: assert property (p_rx) else $error("rx late");

    property p_tx_start;
        @(posedge i_clk) disable iff (!i_rst_b)
        (thr_wr && !tx_pend && !tx_busy && !i_tx_done) ##1 (!thr_wr)[*8] |-> ##[0:15] o_tx_load;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("tx start late");

    property p_tx_early;
        @(posedge i_clk) disable iff (!i_rst_b)
        (thr_wr && !tx_go) |=> !o_tx_load [*7];
    endproperty
    a_tx_early: assert property (p_tx_early) else $error("tx start early");

    property p_transmit_ready_n;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_tx_load |-> ##[1:8] o_transmit_ready_n;
    endproperty
    a_transmit_ready_n: assert property (p_transmit_ready_n) else $error("tx ready held");

    property p_ms_irq;
        @(posedge i_clk) disable iff (!i_rst_b)
        (interrupt_enable_reg[EN_MDM] && |dlt_reg) |-> o_irq;
    endproperty
    a_ms_irq: assert property (p_ms_irq) else $error("modem irq missing");

    property p_dtr;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(modem_output_control_reg[CTL_DTR]) |=> !o_dtr_n;
    endproperty
    a_dtr: assert property (p_dtr) else $error("dtr not driven");

    property p_loop;
        @(posedge i_clk) disable iff (!i_rst_b)
        (loop && $stable(modem_output_control_reg))
            |-> st_now[0] == modem_output_control_reg[CTL_RTS] && st_now[3] == modem_output_control_reg[CTL_OUT2];
    endproperty
    a_loop: assert property (p_loop) else $error("loop status wrong");
endmodule

/* File: sim/ums_modem_model.sv */
// modem side model: drives the four handshake lines of the channel
`timescale 1ns/1ns
module ums_modem_model (
    input  wire logic                i_clk,     // core clock
    input  wire ums_pkg::ums_modem_t i_want,    // requested line levels
    input  wire logic                i_slow,    // answer one cycle late
    output ums_pkg::ums_modem_t      o_modem_n  // lines towards the channel
);
    import ums_pkg::*;

    ums_modem_t lag_reg = 4'hF;

    // delayed copy, a slow peripheral settles one cycle later
    always @(posedge i_clk) begin
        lag_reg <= #1 i_want;
    end

    // slow mode moves the lines just after a clock edge, fast mode passes i_want straight through
    assign o_modem_n = i_slow ? lag_reg : i_want;
endmodule

/* File: sim/tb_ums_channel.sv */
// self-checking bench for the modem status channel
`timescale 1ns/1ns
module tb_ums_channel;
    import ums_pkg::*;

    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       cs_n = 1'b1;
    logic [2:0] addr = 3'h0;
    logic       rd_n = 1'b1;
    logic       wr_n = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       data_oe;
    logic [3:0] lines = 4'hF;
    logic       slow = 1'b0;
    ums_modem_t modem_n;
    logic       rx_stop = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [3:0] rx_err = 4'h0;
    logic       tx_done = 1'b0;
    logic       tx, tx_load, rts_n, dtr_n, irq, irq_oe, rx_rdy_n, tx_rdy_n;
    logic [7:0] tx_byte;
    int         fails = 0;
    int         comparisons = 0;
    int         cycles = 0;

    localparam logic [2:0] RST_ADR [6] = '{ADR_INT_EN, ADR_LINE_FMT, ADR_MDM_CTL, ADR_INT_ST, ADR_LINE_ST, ADR_MDM_ST};
    localparam logic [7:0] RST_VAL [6] = '{INT_EN_RST, LINE_FMT_RST, MDM_CTL_RST, {4'h0, INT_NONE}, LINE_ST_RST, 8'h00};
    localparam logic [7:0] PAT [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};

    ums_channel ums_channel_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_cs_n(cs_n), .i_addr(addr), .i_read_strobe_n(rd_n),
        .i_write_strobe_n(wr_n), .i_data(wdata), .o_data(rdata), .o_data_oe(data_oe),
        .i_modem_n(modem_n), .i_rx_stop(rx_stop), .i_rx_byte(rx_byte), .i_rx_err(rx_err),
        .i_tx_bit(1'b1), .i_tx_done(tx_done), .o_tx(tx), .o_tx_load(tx_load), .o_tx_byte(tx_byte),
        .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_irq(irq), .o_irq_oe(irq_oe),
        .o_receive_ready_n(rx_rdy_n), .o_transmit_ready_n(tx_rdy_n)
    );

    ums_modem_model ums_modem_model_i (
        .i_clk(clk), .i_want(ums_modem_t'(lines)), .i_slow(slow), .o_modem_n(modem_n)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks

    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // write acts at the edge ending the strobe cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        wr_n = 1'b0;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        cs_n = 1'b1;
        wr_n = 1'b1;
    endtask

    // data is taken one cycle after the strobe, then released
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        rd_n = 1'b0;
        addr = a;
        @(posedge clk);
        #1;
        d = rdata;
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask

    task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, exp, d);
        chk("read enable", 8'h01, {7'h0, data_oe});
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence

    initial begin
        int         n;
        logic [7:0] d;
        repeat (8) @(posedge clk);
        #1;
        chk("reset pins", 8'h0E, {4'h0, tx, rts_n, dtr_n, irq_oe});
        rst_b = 1'b1;
        cyc(2);
        chk("pins after reset", 8'h0E, {4'h0, tx, rts_n, dtr_n, irq_oe});
        foreach (RST_ADR[k]) rdc("reset value", RST_ADR[k], RST_VAL[k]);
        $display("test reset_defaults done");

        foreach (PAT[k]) begin
            wr(ADR_SCR, PAT[k]);
            rdc("scratch", ADR_SCR, PAT[k]);
        end
        $display("test scratch done");

        wr(ADR_MDM_CTL, 8'h01);
        cyc(2);
        chk("rts dtr oe", 8'h04, {5'h0, rts_n, dtr_n, irq_oe});
        wr(ADR_MDM_CTL, 8'h02);
        cyc(2);
        chk("rts dtr oe", 8'h02, {5'h0, rts_n, dtr_n, irq_oe});
        wr(ADR_MDM_CTL, 8'h08);
        cyc(2);
        chk("rts dtr oe", 8'h07, {5'h0, rts_n, dtr_n, irq_oe});
        wr(ADR_LINE_FMT, 8'h40);
        cyc(2);
        chk("break line", 8'h00, {7'h0, tx});
        wr(ADR_LINE_FMT, 8'h00);
        cyc(2);
        chk("idle line", 8'h01, {7'h0, tx});
        $display("test modem_outputs done");

        wr(ADR_INT_EN, 8'h08);
        for (int i = 0; i < 4; i++) begin
            slow = i[0];
            cyc(1);
            lines[i] = 1'b0;
            cyc(6);
            chk("irq after fall", {7'h0, i != 2}, {7'h0, irq});
            rdc("status after fall", ADR_MDM_ST, {~lines, (i == 2) ? 4'h0 : 4'(1 << i)});
            cyc(1);
            chk("irq after read", 8'h00, {7'h0, irq});
            lines[i] = 1'b1;
            cyc(6);
            rdc("isr modem", ADR_INT_ST, {4'h0, INT_MDM});
            rdc("status after rise", ADR_MDM_ST, {~lines, 4'(1 << i)});
            rdc("status cleared", ADR_MDM_ST, 8'h00);
        end
        // dsr change lands on the very edge that ends a status read
        slow = 1'b0;
        cyc(1);
        lines[1] = 1'b0;
        rd(ADR_MDM_ST, d);
        rdc("change kept at read", ADR_MDM_ST, 8'h22);
        lines[1] = 1'b1;
        cyc(6);
        rd(ADR_MDM_ST, d);
        $display("test modem_changes done");

        lines = 4'h5;
        wr(ADR_MDM_CTL, 8'h15);
        rd(ADR_MDM_ST, d);
        chk("loop status", 8'h60, d & 8'hF0);
        wr(ADR_MDM_CTL, 8'h1A);
        rd(ADR_MDM_ST, d);
        chk("loop status", 8'h90, d & 8'hF0);
        wr(ADR_MDM_CTL, 8'h00);
        cyc(6);
        rd(ADR_MDM_ST, d);
        chk("normal status", 8'hA0, d & 8'hF0);
        rd(ADR_MDM_ST, d);
        $display("test loop_back done");

        wr(ADR_INT_EN, 8'h0F);
        lines = 4'hF;
        cyc(6);
        rx_byte = 8'hC3;
        rx_err = 4'h2;
        rx_stop = 1'b1;
        cyc(1);
        rx_stop = 1'b0;
        chk("rx ready", 8'h00, {7'h0, rx_rdy_n});
        chk("rx irq", 8'h01, {7'h0, irq});
        rdc("isr line", ADR_INT_ST, {4'h0, INT_LINE});
        rdc("line state", ADR_LINE_ST, 8'h65);
        rdc("isr rx", ADR_INT_ST, {4'h0, INT_RX});
        rdc("rx data", ADR_DATA, 8'hC3);
        rdc("isr tx", ADR_INT_ST, {4'h0, INT_TX});
        rdc("isr modem last", ADR_INT_ST, {4'h0, INT_MDM});
        rdc("changes", ADR_MDM_ST, 8'h0A);
        rdc("isr none", ADR_INT_ST, {4'h0, INT_NONE});
        $display("test priority done");

        wr(ADR_DATA, 8'h96);
        n = 0;
        while (tx_load !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("start delay in range", 8'h01, {7'h0, n >= 8 && n <= 24});
        chk("tx byte", 8'h96, tx_byte);
        n = 0;
        while (tx_rdy_n !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("tx ready drop in range", 8'h01, {7'h0, n <= 8});
        #1;
        tx_done = 1'b1;
        cyc(1);
        tx_done = 1'b0;
        $display("test transmit done");
        report_and_stop();
    end
endmodule
